/* sram_ctrl.sv */
// controller that drives an asynchronous byte-wide static memory
// assumes the memory pins are joined to a tri-state wire by the caller;
// io_lanes_i comes from a pin and is resynchronised by three flops
// Summary of operation
// - each read or write cycle lasts at least 70 ns
// - write ends at the first rise of cs_n or put_strb_n
// - hold cs_n or put_strb_n high while address changes
// - never drive write data while memory may drive read data
// - write data stable before the ending edge and held past it
// - put_strb_n low at least 55 ns
// - address valid at least 60 ns before put_strb_n rises
// - write data valid at least 25 ns before put_strb_n rises
`timescale 1ns/1ns
module sram_ctrl
  import sram_ctrl_pkg::*;
#(
  parameter int unsigned A_W = ADDR_W,
  parameter int unsigned D_W = DATA_W
) (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic req_valid,
  input wire logic req_write,
  input wire logic [A_W-1:0] req_addr,
  input wire logic [D_W-1:0] req_wdata,
  output logic req_ready,
  output logic rsp_valid,
  output logic [D_W-1:0] rsp_rdata,
  output logic cs_n,
  output logic out_drv_n,
  output logic put_strb_n,
  output logic [A_W-1:0] addr_bus,
  output logic [D_W-1:0] io_lanes_o,
  output logic io_lanes_oe,
  input wire logic [D_W-1:0] io_lanes_i
);

  // the pin struct is fixed at the package widths
  if (A_W != ADDR_W || D_W != DATA_W) begin : g_width_check
    $error("sram_ctrl widths must match the package");
  end

  // phase lengths in cycles; the read adds one cycle of sync latency
  // so the second sync flop can already hold settled data; the third holds it a cycle later
  localparam int unsigned WR_LEAD = CYC_ADDR_TO_WH - CYC_WR_PULSE;
  localparam int unsigned WR_PAD = CYC_CYCLE - CYC_ADDR_TO_WH;
  localparam int unsigned RD_WAIT_CYC = CYC_ACCESS + 1;

  // a lead or pad of zero cycles would break the phase order
  if (CYC_ADDR_TO_WH <= CYC_WR_PULSE || CYC_CYCLE <= CYC_ADDR_TO_WH ||
      RD_WAIT_CYC >= (1 << CNT_W)) begin : g_count_check
    $error("sram_ctrl phase counts do not fit the timer");
  end

  typedef struct packed {
    ctrl_state_t state;
    mem_pins_t pins;
    logic req_ready;
    logic rsp_valid;
    logic [D_W-1:0] rdata;
    logic [D_W-1:0] sync1;
    logic [D_W-1:0] sync2;
    logic [D_W-1:0] sync3;
  } ctrl_st_t;

  ctrl_st_t st_q;
  ctrl_st_t st_d;
  user_req_t req;
  logic tmr_load;
  logic [CNT_W-1:0] tmr_val;
  logic tmr_done;

  assign req = '{valid: req_valid, write: req_write, addr: req_addr,
                 wdata: req_wdata};

  // phase timer shared by all states
  cycle_timer #(
    .W(CNT_W)
  ) u_timer (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .load(tmr_load),
    .load_val(tmr_val),
    .expired(tmr_done)
  );

  // next-state logic; every access holds cs_n low for the full cycle time
  always_comb begin
    st_d = st_q;
    tmr_load = 1'b0;
    tmr_val = '0;
    st_d.rsp_valid = 1'b0;
    // three-flop resynchroniser; only sync2/sync3 are looked at
    st_d.sync1 = io_lanes_i;
    st_d.sync2 = st_q.sync1;
    st_d.sync3 = st_q.sync2;
    unique case (st_q.state)
      IDLE: begin
        st_d.req_ready = 1'b1;
        if (req.valid && st_q.req_ready) begin
          st_d.req_ready = 1'b0;
          // address set while put_strb_n stays high; cs_n falls with it
          st_d.pins.addr_bus = req.addr;
          st_d.pins.cs_n = 1'b0;
          tmr_load = 1'b1;
          if (req.write) begin
            // out_drv_n stays high so the memory never drives
            st_d.pins.out_drv_n = 1'b1;
            st_d.pins.io_lanes_o = req.wdata;
            st_d.pins.io_lanes_oe = 1'b1;
            tmr_val = CNT_W'(WR_LEAD);
            st_d.state = WR_SETUP;
          end else begin
            // both enables fall with the address so share one wait
            st_d.pins.out_drv_n = 1'b0;
            st_d.pins.put_strb_n = 1'b1;
            // plus sync latency, since data is valid only after access
            tmr_val = CNT_W'(RD_WAIT_CYC);
            st_d.state = RD_WAIT;
          end
        end
      end
      RD_WAIT: begin
        // a memory whose lanes never settle stalls here; there is no
        // time limit, since a read abandoned early would return garbage
        // sample once sync2 and sync3 agree on settled data
        if (tmr_done && st_q.sync2 == st_q.sync3) begin
          st_d.rdata = st_q.sync3;
          st_d.rsp_valid = 1'b1;
          st_d.pins.out_drv_n = 1'b1;
          st_d.pins.cs_n = 1'b1;
          tmr_load = 1'b1;
          tmr_val = CNT_W'(CYC_RELEASE);
          st_d.state = RD_RELEASE;
        end
      end
      RD_RELEASE: begin
        // wait out the release so a following write sees no contention
        if (tmr_done) begin
          st_d.state = IDLE;
        end
      end
      WR_SETUP: begin
        // address leads the strobe so 60 ns hold before rise is met
        if (tmr_done) begin
          st_d.pins.put_strb_n = 1'b0;
          tmr_load = 1'b1;
          tmr_val = CNT_W'(CYC_WR_PULSE);
          st_d.state = WR_STROBE;
        end
      end
      WR_STROBE: begin
        // data was driven long before, so setup exceeds 25 ns
        if (tmr_done) begin
          st_d.pins.put_strb_n = 1'b1;
          st_d.state = WR_HOLD;
        end
      end
      WR_HOLD: begin
        // data and address held one cycle past the rising strobe
        st_d.pins.cs_n = 1'b1;
        st_d.pins.io_lanes_oe = 1'b0;
        st_d.rsp_valid = 1'b1;
        tmr_load = 1'b1;
        tmr_val = CNT_W'(WR_PAD);
        st_d.state = CYC_PAD;
      end
      CYC_PAD: begin
        // pad the write out to the full cycle time
        if (tmr_done) begin
          st_d.state = IDLE;
        end
      end
      // the eighth code of the state field is unused; recover to idle
      default: begin
        st_d.state = IDLE;
      end
    endcase
  end

  // all state registered together; reset parks the memory deselected
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      // clearing the whole struct first leaves no field unset
      st_q <= '0;
      st_q.state <= IDLE;
      st_q.pins.cs_n <= 1'b1;
      st_q.pins.out_drv_n <= 1'b1;
      st_q.pins.put_strb_n <= 1'b1;
    end else begin
      st_q <= st_d;
    end
  end

  // outputs straight from flops; the memory itself needs no clock
  assign req_ready = st_q.req_ready;
  assign rsp_valid = st_q.rsp_valid;
  assign rsp_rdata = st_q.rdata;
  assign cs_n = st_q.pins.cs_n;
  assign out_drv_n = st_q.pins.out_drv_n;
  assign put_strb_n = st_q.pins.put_strb_n;
  assign addr_bus = st_q.pins.addr_bus;
  assign io_lanes_o = st_q.pins.io_lanes_o;
  assign io_lanes_oe = st_q.pins.io_lanes_oe;

endmodule

/* sram_ctrl_pkg.sv */
// package for the asynchronous byte memory controller
// assumes a 250 MHz sys_clk; the cycle count of every device time is derived here
package sram_ctrl_pkg;

  localparam int unsigned CLK_PERIOD_NS = 4;
  localparam int unsigned ADDR_W = 19;
  localparam int unsigned DATA_W = 8;

  // device timing in ns
  localparam int unsigned T_CYCLE_NS = 70;
  localparam int unsigned T_ACCESS_NS = 70;
  localparam int unsigned T_WR_PULSE_NS = 55;
  localparam int unsigned T_ADDR_TO_WH_NS = 60;
  localparam int unsigned T_DATA_SETUP_NS = 25;
  localparam int unsigned T_RELEASE_NS = 25;

  // least times round up to whole cycles
  localparam int unsigned CYC_CYCLE =
    (T_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned CYC_ACCESS =
    (T_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned CYC_WR_PULSE =
    (T_WR_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned CYC_ADDR_TO_WH =
    (T_ADDR_TO_WH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned CYC_DATA_SETUP =
    (T_DATA_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned CYC_RELEASE =
    (T_RELEASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  localparam int unsigned CNT_W = 6;

  typedef enum logic [2:0] {
    IDLE, RD_WAIT, RD_RELEASE, WR_SETUP, WR_STROBE,
    WR_HOLD, CYC_PAD
  } ctrl_state_t;

  // memory pin group driven toward the device
  typedef struct packed {
    logic cs_n;
    logic out_drv_n;
    logic put_strb_n;
    logic [ADDR_W-1:0] addr_bus;
    logic [DATA_W-1:0] io_lanes_o;
    logic io_lanes_oe;
  } mem_pins_t;

  // user request
  typedef struct packed {
    logic valid;
    logic write;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } user_req_t;

endpackage

/* cycle_timer.sv */
// down counter that times each phase of a memory access
// assumes the load value fits the counter width
`timescale 1ns/1ns
module cycle_timer
  import sram_ctrl_pkg::*;
#(
  parameter int unsigned W = CNT_W
) (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic load,
  input wire logic [W-1:0] load_val,
  output logic expired
);

  // a zero-width counter cannot time any phase
  if (W < 1) begin : g_w_check
    $error("cycle_timer needs a counter of at least one bit");
  end

  typedef struct packed {
    logic [W-1:0] cnt;
  } timer_st_t;

  timer_st_t st_q;
  timer_st_t st_d;

  // reload wins over counting so back-to-back phases never slip a cycle
  always_comb begin
    st_d = st_q;
    if (load) begin
      st_d.cnt = load_val;
    end else if (st_q.cnt != '0) begin
      st_d.cnt = st_q.cnt - W'(1);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  // done is the count alone; folding load in would loop through the
  // caller, which reloads on done
  assign expired = (st_q.cnt == '0);

endmodule

/* sram_ctrl_sva.sv */
// checker for the memory-side pins of the byte memory controller
// assumes binding onto sram_ctrl; one clock, sync active-low reset
`timescale 1ns/1ns
module sram_ctrl_sva #(
  parameter int unsigned A_W = 19,
  parameter int unsigned D_W = 8
) (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic cs_n,
  input wire logic out_drv_n,
  input wire logic put_strb_n,
  input wire logic [A_W-1:0] addr_bus,
  input wire logic [D_W-1:0] io_lanes_o,
  input wire logic io_lanes_oe
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  // cycles since the last select; saturates so long idles stay legal
  logic [4:0] gap_q;
  always_ff @(posedge sys_clk) begin
    if (!resetn) gap_q <= 5'h1F;
    else if ($fell(cs_n)) gap_q <= 5'h00;
    else if (gap_q != 5'h1F) gap_q <= gap_q + 5'h01;
  end
  // a strobe forced high by reset is no write end, so it is skipped
  sequence s_wr_rise; $rose(put_strb_n) && $past(resetn); endsequence
  sequence s_wr_done; cs_n && !io_lanes_oe; endsequence
  sequence s_bus_quiet; (!io_lanes_oe)[*7]; endsequence
  property p_cycle_len; $fell(cs_n) |-> gap_q >= 5'd17; endproperty
  property p_wr_end; s_wr_rise |=> s_wr_done; endproperty
  property p_addr_move; $changed(addr_bus) |-> cs_n || put_strb_n;
  endproperty
  property p_no_fight; $rose(out_drv_n) |-> s_bus_quiet; endproperty
  property p_data_hold;
    s_wr_rise |-> io_lanes_oe ##1 $stable(io_lanes_o);
  endproperty
  property p_wr_pulse; s_wr_rise |-> !$past(put_strb_n, 14);
  endproperty
  property p_addr_setup;
    s_wr_rise |-> addr_bus == $past(addr_bus, 15);
  endproperty
  property p_data_setup; s_wr_rise |-> $past(io_lanes_oe, 7)
    && io_lanes_o == $past(io_lanes_o, 7); endproperty
  a_cycle_len: assert property (p_cycle_len)
    else $error("cycle too short");
  a_wr_end: assert property (p_wr_end)
    else $error("write end wrong");
  a_addr_move: assert property (p_addr_move)
    else $error("address moved in write");
  a_no_fight: assert property (p_no_fight)
    else $error("drove into read data");
  a_data_hold: assert property (p_data_hold)
    else $error("write data not held");
  a_wr_pulse: assert property (p_wr_pulse)
    else $error("strobe too short");
  a_addr_setup: assert property (p_addr_setup)
    else $error("address setup short");
  a_data_setup: assert property (p_data_setup)
    else $error("data setup short");
endmodule

/* sram_dev_model.sv */
// behavioural byte memory seen from its pins
// assumes the bench resolves the shared data wire from both enables
`timescale 1ns/1ns
module sram_dev_model (
  input wire logic cs_n,
  input wire logic out_drv_n,
  input wire logic put_strb_n,
  input wire logic [18:0] addr_bus,
  input wire logic [7:0] bus_in,
  output logic drv,
  output logic [7:0] dq
);
  logic [7:0] mem [0:524287]; // static, no refresh
  logic en, sel_late, en_late;
  logic [18:0] addr_late, addr_hold;
  // read drive only when selected, strobe high, drive enable low
  assign en = !cs_n && !out_drv_n && put_strb_n;
  // turn on early, release as late as allowed, to expose fights
  assign #(5, 25) drv = en;
  assign #(70, 0) sel_late = !cs_n;
  assign #(35, 0) en_late = en;
  assign #70 addr_late = addr_bus;
  assign #10 addr_hold = addr_bus; // old byte lingers briefly
  // garbage until every access time is up
  assign dq = (sel_late && en_late && addr_late === addr_hold) ?
    mem[addr_hold] : ~mem[addr_hold];
  // byte taken at the first rise that ends the write
  always @(posedge cs_n or posedge put_strb_n)
    if (!cs_n || !put_strb_n) mem[addr_bus] = bus_in;
endmodule

/* tb_sram_ctrl.sv */
// self-checking bench for the byte memory controller
// assumes sram_dev_model answers on the far side of the pins
`timescale 1ns/1ns
module tb_sram_ctrl;
  logic sys_clk = 0, resetn = 0, req_valid = 0, req_write = 0;
  logic [18:0] req_addr = '0, addr_bus;
  logic [7:0] req_wdata = '0, rsp_rdata, io_lanes_o, dq, lanes;
  logic req_ready, rsp_valid, cs_n, out_drv_n, put_strb_n;
  logic io_lanes_oe, drv;
  int err_total = 0, n_compared = 0, cyc = 0;
  logic [18:0] ta [4] = '{19'h0_0000, 19'h7_FFFF, 19'h2_AAAA, 19'h0_0000};
  logic [7:0] td [4] = '{8'h5A, 8'hA5, 8'h0F, 8'hF0};
  always #2 sys_clk = ~sys_clk;
  // shared wire; a fight shows as unknown, a floating bus as noise
  assign lanes = (io_lanes_oe && drv) ? 'x : io_lanes_oe ? io_lanes_o :
    drv ? dq : ~io_lanes_o;
  sram_ctrl uut (.sys_clk, .resetn, .req_valid, .req_write, .req_addr,
    .req_wdata, .req_ready, .rsp_valid, .rsp_rdata, .cs_n, .out_drv_n,
    .put_strb_n, .addr_bus, .io_lanes_o, .io_lanes_oe, .io_lanes_i(lanes));
  sram_dev_model mdl (.cs_n, .out_drv_n, .put_strb_n, .addr_bus,
    .bus_in(lanes), .drv, .dq);
  task automatic tally_and_finish;
    $display("compared %0d errors %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] exp, got);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // bounded wait for a flag seen high at a clock edge
  task automatic wait_hi(ref logic s, input string nm);
    int n;
    n = 0;
    do begin @(posedge sys_clk); n++; end while (s !== 1'b1 && n < 60);
    chk(nm, 1, s);
  endtask
  task automatic take(input logic w, input logic [18:0] a,
    input logic [7:0] d);
    wait_hi(req_ready, "ready");
    req_valid <= 1'b1;
    req_write <= w;
    req_addr <= a;
    req_wdata <= d;
    @(posedge sys_clk);
  endtask
  task automatic op(input logic w, input logic [18:0] a,
    input logic [7:0] d);
    take(w, a, d);
    req_valid <= 1'b0;
    wait_hi(rsp_valid, "response");
  endtask
  // back-to-back writes at both ends of the range, then readback
  task automatic t_rw;
    for (int i = 0; i < 4; i++) op(1'b1, ta[i], td[i]);
    for (int i = 1; i < 4; i++) begin
      op(1'b0, ta[i], 8'h00);
      chk("read data", td[i], rsp_rdata);
    end
    chk("top byte", td[1], mdl.mem[19'h7_FFFF]);
  endtask
  // a request held while busy must be ignored
  task automatic t_refuse;
    op(1'b1, 19'h0_0002, 8'h3C);
    take(1'b1, 19'h0_0001, 8'h11);
    req_addr <= 19'h0_0002;
    req_wdata <= 8'hC3;
    repeat (8) @(posedge sys_clk);
    req_valid <= 1'b0;
    wait_hi(rsp_valid, "response");
    chk("kept byte", 8'h3C, mdl.mem[2]);
    chk("taken byte", 8'h11, mdl.mem[1]);
  endtask
  // reset in mid-write, then normal traffic again
  task automatic t_abort;
    take(1'b1, 19'h0_0003, 8'h77);
    req_valid <= 1'b0;
    repeat (4) @(posedge sys_clk);
    resetn <= 1'b0;
    repeat (2) @(posedge sys_clk);
    chk("idle pins", 4'b1110,
      {cs_n, out_drv_n, put_strb_n, io_lanes_oe});
    resetn <= 1'b1;
    op(1'b1, 19'h0_0004, 8'hA9);
    op(1'b0, 19'h0_0004, 8'h00);
    chk("after reset", 8'hA9, rsp_rdata);
  endtask
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      tally_and_finish();
    end
  end
  initial begin
    repeat (16) @(posedge sys_clk);
    chk("reset pins", 4'b1110,
      {cs_n, out_drv_n, put_strb_n, io_lanes_oe});
    resetn <= 1'b1;
    t_rw();
    t_refuse();
    t_abort();
    tally_and_finish();
  end
endmodule
bind sram_ctrl sram_ctrl_sva #(.A_W(A_W), .D_W(D_W)) sva (.sys_clk,
  .resetn, .cs_n, .out_drv_n, .put_strb_n, .addr_bus, .io_lanes_o,
  .io_lanes_oe);
